// ==== lceq_regs.vh ====
// Register map, field positions and reset values for the link control and equalizer bank
`ifndef LCEQ_REGS_VH
`define LCEQ_REGS_VH

`define LCEQ_ADDR_W          8
`define LCEQ_OFF_FAULT       8'h41
`define LCEQ_OFF_BACKCH      8'h43
`define LCEQ_OFF_EQ_OVR      8'h44
`define LCEQ_OFF_EQ_FLOOR    8'h45
`define LCEQ_OFF_CTRL        8'h46
`define LCEQ_OFF_STATUS      8'h47
`define LCEQ_OFF_IRQ_MASK    8'h48

`define LCEQ_RST_FAULT       8'h03
`define LCEQ_RST_BACKCH      8'h00
`define LCEQ_RST_EQ_OVR      8'h60
`define LCEQ_RST_EQ_FLOOR    8'h80
`define LCEQ_RST_CTRL        8'h00
`define LCEQ_RST_MASK        8'h00

`define LCEQ_FAULT_EN_BIT    4
`define LCEQ_FAULT_THR_HI    3
`define LCEQ_FAULT_THR_LO    0
`define LCEQ_MISO_REL_BIT    4
`define LCEQ_CPOL_BIT        3
`define LCEQ_MODE_HI         2
`define LCEQ_MODE_LO         0
`define LCEQ_EQ_UP_HI        7
`define LCEQ_EQ_UP_LO        5
`define LCEQ_EQ_LOW_HI       3
`define LCEQ_EQ_LOW_LO       1
`define LCEQ_EQ_BYP_BIT      0
`define LCEQ_FLOOR_HI        3
`define LCEQ_FLOOR_LO        0
`define LCEQ_CTRL_PORT_BIT   0
`define LCEQ_CTRL_FLEN_BIT   1

`define LCEQ_MODE_NORMAL     3'h0
`define LCEQ_MODE_GPIO1      3'h1
`define LCEQ_MODE_GPIO2      3'h2
`define LCEQ_MODE_GPIO4      3'h3
`define LCEQ_MODE_RSVD_A     3'h4
`define LCEQ_MODE_RSVD_B     3'h5
`define LCEQ_MODE_FWD_SPI    3'h6
`define LCEQ_MODE_REV_SPI    3'h7

`define LCEQ_ST_LOCK_LOST    0
`define LCEQ_ST_LINK_ERR     1
`define LCEQ_ST_BAD_MODE     2
`define LCEQ_ST_W            3

`endif

// ==== lceq_top.v ====
// Link fault monitor, back-channel mode and equalizer override register bank
//
// What this block does
// - Count link errors only while the count enable bit is one.
// - Four-bit error threshold, default three, counter on pixel clock enable.
// - Watch both embedded edge bits and control word; drop lock at threshold.
// - With counting disabled, one link error drops lock.
// - Reverse SPI: data-out always driven, or released while select is low.
// - Polarity zero launches falling, samples rising; one the reverse.
// - Mode codes 000 to 011 select normal, one, two or four fast GPIOs.
// - Code 110 forward SPI, 111 reverse SPI; 100 and 101 reserved.
// - Bypass bit one disables adaptive equalization; zero keeps it running.
// - Bypassed setting is upper three bits then lower three bits.
// - Second-port select steers override register writes to second port.
// - Second-port select steers floor register to second port equalizer.
// - When floor enabled, adaptation starts from the four-bit floor value.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "lceq_regs.vh"

module lceq_top (
	input  wire       i_sys_clk,
	input  wire       i_srst,
	input  wire [7:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	output reg  [7:0] o_rdata,
	input  wire       i_pix_en,
	input  wire       i_edge_bit_a_err,
	input  wire       i_edge_bit_b_err,
	input  wire       i_control_payload_word_err,
	input  wire       i_lock_acquired,
	output reg        o_lock,
	input  wire       i_spi_select,
	input  wire       i_spi_miso_data,
	output wire       o_spi_miso,
	output wire       o_spi_miso_oe,
	output wire       o_spi_launch_rising,
	output wire       o_spi_sample_rising,
	output wire [2:0] o_fast_gpio_count,
	output wire       o_fwd_spi_en,
	output wire       o_rev_spi_en,
	input  wire       i_floor_pin_en,
	output reg        o_eq0_adapt_en,
	output reg  [5:0] o_eq0_setting,
	output reg  [3:0] o_eq0_floor,
	output reg        o_eq0_floor_en,
	output reg        o_eq1_adapt_en,
	output reg  [5:0] o_eq1_setting,
	output reg  [3:0] o_eq1_floor,
	output reg        o_eq1_floor_en,
	output wire       o_irq
);

	// Register storage, one override and floor copy per port
	reg  [7:0]            fault_r;
	reg  [7:0]            backch_r;
	reg  [7:0]            eq_ovr0_r;
	reg  [7:0]            eq_ovr1_r;
	reg  [7:0]            eq_floor0_r;
	reg  [7:0]            eq_floor1_r;
	reg  [7:0]            ctrl_r;
	reg  [7:0]            mask_r;
	reg  [`LCEQ_ST_W-1:0] status_r;
	reg  [`LCEQ_ST_W-1:0] status_nxt;
	reg  [3:0]            err_cnt_r;
	reg  [3:0]            err_cnt_nxt;
	reg                   lock_nxt;
	reg  [7:0]            rdata_nxt;

	wire       port_sel   = ctrl_r[`LCEQ_CTRL_PORT_BIT];
	wire       cnt_en     = fault_r[`LCEQ_FAULT_EN_BIT];
	wire [3:0] threshold  = fault_r[`LCEQ_FAULT_THR_HI:`LCEQ_FAULT_THR_LO];
	wire [2:0] mode       = backch_r[`LCEQ_MODE_HI:`LCEQ_MODE_LO];
	wire       wr_fault   = i_wr && (i_addr == `LCEQ_OFF_FAULT);
	wire       rd_status  = i_rd && (i_addr == `LCEQ_OFF_STATUS);

	wire       link_err   = i_pix_en &&
		(i_edge_bit_a_err || i_edge_bit_b_err || i_control_payload_word_err);
	wire       bad_mode   = (mode == `LCEQ_MODE_RSVD_A) || (mode == `LCEQ_MODE_RSVD_B);
	wire       lose_lock  = o_lock && link_err &&
		(!cnt_en || (err_cnt_r + 4'h1 >= threshold));

	// Register writes; reserved bits are kept so they read back
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			fault_r     <= `LCEQ_RST_FAULT;
			backch_r    <= `LCEQ_RST_BACKCH;
			eq_ovr0_r   <= `LCEQ_RST_EQ_OVR;
			eq_ovr1_r   <= `LCEQ_RST_EQ_OVR;
			eq_floor0_r <= `LCEQ_RST_EQ_FLOOR;
			eq_floor1_r <= `LCEQ_RST_EQ_FLOOR;
			ctrl_r      <= `LCEQ_RST_CTRL;
			mask_r      <= `LCEQ_RST_MASK;
		end else if (i_wr) begin
			if (i_addr == `LCEQ_OFF_FAULT) begin
				fault_r <= i_wdata;
			end else if (i_addr == `LCEQ_OFF_BACKCH) begin
				backch_r <= i_wdata;
			end else if (i_addr == `LCEQ_OFF_EQ_OVR) begin
				if (port_sel)
					eq_ovr1_r <= i_wdata;
				else
					eq_ovr0_r <= i_wdata;
			end else if (i_addr == `LCEQ_OFF_EQ_FLOOR) begin
				if (port_sel)
					eq_floor1_r <= i_wdata;
				else
					eq_floor0_r <= i_wdata;
			end else if (i_addr == `LCEQ_OFF_CTRL) begin
				ctrl_r <= i_wdata;
			end else if (i_addr == `LCEQ_OFF_IRQ_MASK) begin
				mask_r <= i_wdata;
			end
		end
	end

	// Error counter and lock state
	always @* begin
		err_cnt_nxt = err_cnt_r;
		lock_nxt    = o_lock;
		if (!o_lock) begin
			err_cnt_nxt = 4'h0;
			if (i_lock_acquired)
				lock_nxt = 1'b1;
		end else if (!cnt_en || wr_fault) begin
			err_cnt_nxt = 4'h0;
			if (!cnt_en && link_err)
				lock_nxt = 1'b0;
		end else if (link_err) begin
			err_cnt_nxt = err_cnt_r + 4'h1;
			if (lose_lock)
				lock_nxt = 1'b0;
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			err_cnt_r <= 4'h0;
			o_lock    <= 1'b0;
		end else begin
			err_cnt_r <= err_cnt_nxt;
			o_lock    <= lock_nxt;
		end
	end

	// Sticky events, set wins over the read clear
	always @* begin
		status_nxt = rd_status ? {`LCEQ_ST_W{1'b0}} : status_r;
		if (o_lock && !lock_nxt)
			status_nxt[`LCEQ_ST_LOCK_LOST] = 1'b1;
		if (link_err && o_lock)
			status_nxt[`LCEQ_ST_LINK_ERR] = 1'b1;
		if (bad_mode)
			status_nxt[`LCEQ_ST_BAD_MODE] = 1'b1;
	end

	always @(posedge i_sys_clk) begin
		if (i_srst)
			status_r <= {`LCEQ_ST_W{1'b0}};
		else
			status_r <= status_nxt;
	end

	assign o_irq = |(status_r & mask_r[`LCEQ_ST_W-1:0]);

	// Read mux; data valid the cycle after the strobe, unmapped reads zero
	always @* begin
		rdata_nxt = 8'h00;
		if (i_addr == `LCEQ_OFF_FAULT)
			rdata_nxt = fault_r;
		else if (i_addr == `LCEQ_OFF_BACKCH)
			rdata_nxt = backch_r;
		else if (i_addr == `LCEQ_OFF_EQ_OVR)
			rdata_nxt = port_sel ? eq_ovr1_r : eq_ovr0_r;
		else if (i_addr == `LCEQ_OFF_EQ_FLOOR)
			rdata_nxt = port_sel ? eq_floor1_r : eq_floor0_r;
		else if (i_addr == `LCEQ_OFF_CTRL)
			rdata_nxt = ctrl_r;
		else if (i_addr == `LCEQ_OFF_STATUS)
			rdata_nxt = {{(8-`LCEQ_ST_W){1'b0}}, status_r};
		else if (i_addr == `LCEQ_OFF_IRQ_MASK)
			rdata_nxt = mask_r;
	end

	always @(posedge i_sys_clk) begin
		if (i_srst)
			o_rdata <= 8'h00;
		else if (i_rd)
			o_rdata <= rdata_nxt;
		else
			o_rdata <= 8'h00;
	end

	assign o_fast_gpio_count = (mode == `LCEQ_MODE_GPIO1) ? 3'h1 :
		(mode == `LCEQ_MODE_GPIO2) ? 3'h2 :
		(mode == `LCEQ_MODE_GPIO4) ? 3'h4 : 3'h0;
	// SPI tunnel modes, reserved codes enable nothing
	assign o_fwd_spi_en = (mode == `LCEQ_MODE_FWD_SPI);
	assign o_rev_spi_en = (mode == `LCEQ_MODE_REV_SPI);

	assign o_spi_launch_rising = backch_r[`LCEQ_CPOL_BIT];
	assign o_spi_sample_rising = !backch_r[`LCEQ_CPOL_BIT];

	assign o_spi_miso_oe = o_rev_spi_en &&
		(!backch_r[`LCEQ_MISO_REL_BIT] || i_spi_select);
	assign o_spi_miso = o_spi_miso_oe ? i_spi_miso_data : 1'b0;

	// Equalizer controls per port, registered so they stay glitch free
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_eq0_adapt_en <= 1'b1;
			o_eq1_adapt_en <= 1'b1;
			o_eq0_setting  <= 6'h00;
			o_eq1_setting  <= 6'h00;
			o_eq0_floor    <= 4'h0;
			o_eq1_floor    <= 4'h0;
			o_eq0_floor_en <= 1'b0;
			o_eq1_floor_en <= 1'b0;
		end else begin
			o_eq0_adapt_en <= !eq_ovr0_r[`LCEQ_EQ_BYP_BIT];
			o_eq1_adapt_en <= !eq_ovr1_r[`LCEQ_EQ_BYP_BIT];
			o_eq0_setting  <= eq_ovr0_r[`LCEQ_EQ_BYP_BIT] ?
				{eq_ovr0_r[`LCEQ_EQ_UP_HI:`LCEQ_EQ_UP_LO],
				eq_ovr0_r[`LCEQ_EQ_LOW_HI:`LCEQ_EQ_LOW_LO]} : 6'h00;
			o_eq1_setting  <= eq_ovr1_r[`LCEQ_EQ_BYP_BIT] ?
				{eq_ovr1_r[`LCEQ_EQ_UP_HI:`LCEQ_EQ_UP_LO],
				eq_ovr1_r[`LCEQ_EQ_LOW_HI:`LCEQ_EQ_LOW_LO]} : 6'h00;
			o_eq0_floor    <= eq_floor0_r[`LCEQ_FLOOR_HI:`LCEQ_FLOOR_LO];
			o_eq1_floor    <= eq_floor1_r[`LCEQ_FLOOR_HI:`LCEQ_FLOOR_LO];
			o_eq0_floor_en <= i_floor_pin_en || ctrl_r[`LCEQ_CTRL_FLEN_BIT];
			o_eq1_floor_en <= i_floor_pin_en || ctrl_r[`LCEQ_CTRL_FLEN_BIT];
		end
	end

endmodule

// ==== lceq_top_asserts.sv ====
// Port-level checker for the link control and equalizer bank
`timescale 1ns/1ps
module lceq_chk (
	input wire       i_sys_clk,
	input wire       i_srst,
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire       i_wr,
	input wire       i_pix_en,
	input wire       i_edge_bit_a_err,
	input wire       i_edge_bit_b_err,
	input wire       i_control_payload_word_err,
	input wire       o_lock,
	input wire       o_spi_miso_oe,
	input wire       o_spi_launch_rising,
	input wire       o_spi_sample_rising,
	input wire [2:0] o_fast_gpio_count,
	input wire       o_fwd_spi_en,
	input wire       o_rev_spi_en,
	input wire       o_eq0_adapt_en,
	input wire [5:0] o_eq0_setting,
	input wire       o_irq
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	// Mode register writes and qualified link errors
	wire mw   = i_wr && i_addr == 8'h43;
	wire perr = i_pix_en && (i_edge_bit_a_err || i_edge_bit_b_err || i_control_payload_word_err);
	chk_fwd_mode: assert property (mw && i_wdata[2:0] == 3'h6 |=> o_fwd_spi_en && !o_rev_spi_en)
		else $error("forward spi mode not decoded");
	chk_rev_mode: assert property (mw && i_wdata[2:0] == 3'h7 |=> o_rev_spi_en && !o_fwd_spi_en)
		else $error("reverse spi mode not decoded");
	chk_gpio_four: assert property (mw && i_wdata[2:0] == 3'h3 |=> o_fast_gpio_count == 3'h4)
		else $error("four gpio mode not decoded");
	chk_cpol_edge: assert property (mw && i_wdata[3] |=> o_spi_launch_rising && !o_spi_sample_rising)
		else $error("clock polarity edges wrong");
	chk_miso_mode: assert property (o_spi_miso_oe |-> o_rev_spi_en)
		else $error("data-out driven outside reverse spi");
	chk_miso_drive: assert property (mw && i_wdata[4:0] == 5'h07 |=> o_spi_miso_oe)
		else $error("data-out not driven continuously");
	chk_lock_cause: assert property ($fell(o_lock) |-> $past(perr))
		else $error("lock dropped without a link error");
	chk_bypass_zero: assert property (o_eq0_adapt_en |-> o_eq0_setting == 6'h00)
		else $error("manual setting while adapting");
	cover property ($fell(o_lock));
	cover property (o_spi_miso_oe);
	cover property (o_irq);
endmodule
bind lceq_top lceq_chk u_chk (.*);

// ==== lceq_ser_model.sv ====
// Behavioural paired serializer: pixel pacing, link errors and lock
`timescale 1ns/1ps
module lceq_ser_model (
	input  wire       i_sys_clk,
	input  wire [1:0] i_err_sel,
	input  wire       i_relock,
	output reg        o_pix_en,
	output reg  [2:0] o_err,
	output reg        o_lock_acq
);
	initial o_pix_en = 1'b0;
	initial o_err = 3'h0;
	initial o_lock_acq = 1'b0;
	// Pixel enable every other cycle; an error flag only beside it
	always @(posedge i_sys_clk) begin
		o_pix_en <= ~o_pix_en;
		o_err <= (!o_pix_en && i_err_sel != 2'h0) ? 3'h1 << (i_err_sel - 2'h1) : 3'h0;
		o_lock_acq <= i_relock;
	end
endmodule

// ==== lceq_top_bench.sv ====
// Self-checking bench for the link control and equalizer bank
`timescale 1ns/1ps
module lceq_top_bench;
	logic       i_sys_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, relock = 1'b0;
	logic       i_spi_select = 1'b0, i_spi_miso_data = 1'b1, i_floor_pin_en = 1'b0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
	logic [1:0] esel = 2'h0;
	logic       i_pix_en, i_lock_acquired, i_edge_bit_a_err, i_edge_bit_b_err, o_lock;
	logic       i_control_payload_word_err, o_spi_miso, o_spi_miso_oe, o_irq;
	logic       o_spi_launch_rising, o_spi_sample_rising, o_fwd_spi_en, o_rev_spi_en;
	logic       o_eq0_adapt_en, o_eq0_floor_en, o_eq1_adapt_en, o_eq1_floor_en;
	logic [5:0] o_eq0_setting, o_eq1_setting;
	logic [3:0] o_eq0_floor, o_eq1_floor;
	logic [2:0] o_fast_gpio_count;
	logic [2:0] cd [0:5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	logic [2:0] gp [0:5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0, 3'h0};
	int         err_count = 0, num_checks = 0, i;
	lceq_top DUT (.*);
	lceq_ser_model u_ser (.i_sys_clk(i_sys_clk), .i_err_sel(esel), .i_relock(relock),
		.o_pix_en(i_pix_en), .o_lock_acq(i_lock_acquired),
		.o_err({i_control_payload_word_err, i_edge_bit_b_err, i_edge_bit_a_err}));
	// Free-running system clock
	initial begin
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	task chk(input [7:0] got, input [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		cyc(2);
	endtask
	task rd(input [7:0] a, input [7:0] exp);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask
	// One link error of the chosen kind, then time for lock to react
	task inj(input [1:0] s);
		@(posedge i_sys_clk);
		esel <= s;
		repeat (2) @(posedge i_sys_clk);
		esel <= 2'h0;
		cyc(3);
	endtask
	task lock_up;
		@(posedge i_sys_clk);
		relock <= 1'b1;
		@(posedge i_sys_clk);
		relock <= 1'b0;
		cyc(4);
	endtask
	task end_sim;
		$display("Checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task t_reset;
		rd(8'h41, 8'h03);
		rd(8'h43, 8'h00);
		rd(8'h44, 8'h60);
		rd(8'h45, 8'h80);
		rd(8'h4a, 8'h00);
		chk(o_eq0_adapt_en, 1);
		$display("reset values done");
	endtask
	task t_modes;
		for (i = 0; i < 6; i++) begin
			wr(8'h43, {5'h00, cd[i]});
			chk(o_fast_gpio_count, gp[i]);
			chk({o_fwd_spi_en, o_rev_spi_en}, {cd[i] == 3'h6, cd[i] == 3'h7});
		end
		wr(8'h43, 8'h04);
		chk({o_fast_gpio_count, o_fwd_spi_en, o_rev_spi_en, o_irq}, 0);
		rd(8'h47, 8'h04);
		wr(8'h43, 8'h0f);
		chk({o_spi_launch_rising, o_spi_sample_rising, o_spi_miso_oe, o_spi_miso}, 8'h0b);
		rd(8'h47, 8'h04);
		rd(8'h47, 8'h00);
		wr(8'h43, 8'h17);
		chk(o_spi_miso_oe, 0);
		@(posedge i_sys_clk);
		i_spi_select <= 1'b1;
		cyc(1);
		chk({o_spi_launch_rising, o_spi_miso_oe}, 8'h01);
		$display("back-channel modes done");
	endtask
	task t_eq;
		wr(8'h44, 8'hb7);
		chk({o_eq0_adapt_en, o_eq0_setting}, 8'h2b);
		rd(8'h44, 8'hb7);
		wr(8'h46, 8'h03);
		wr(8'h44, 8'h4d);
		chk({1'b0, o_eq1_adapt_en, o_eq1_setting}, 8'h16);
		chk({2'h0, o_eq0_setting}, 8'h2b);
		rd(8'h44, 8'h4d);
		wr(8'h45, 8'h85);
		chk({o_eq1_floor, o_eq0_floor}, 8'h50);
		chk(o_eq1_floor_en, 1);
		chk(o_eq0_floor_en, 1);
		$display("equalizer controls done");
	endtask
	task t_lock;
		wr(8'h48, 8'h01);
		lock_up();
		wr(8'h41, 8'h13);
		inj(2'h1);
		inj(2'h2);
		chk(o_lock, 1);
		inj(2'h3);
		chk({o_lock, o_irq}, 1);
		rd(8'h47, 8'h03);
		chk(o_irq, 0);
		lock_up();
		inj(2'h1);
		inj(2'h2);
		chk(o_lock, 1);
		wr(8'h41, 8'h03);
		inj(2'h3);
		chk(o_lock, 0);
		$display("link fault monitor done");
	endtask
	// Main sequence after reset
	initial begin
		repeat (5) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		t_reset();
		t_modes();
		t_eq();
		t_lock();
		end_sim();
	end
	// Watchdog against a hung sequence
	initial begin
		#200000;
		err_count++;
		end_sim();
	end
endmodule
